// ===== verilog/lstc_pkg.sv
package lstc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ARG0 = 8'h04;
  localparam logic [7:0] ADDR_ARG1 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_RES_LO = 8'h14;
  localparam logic [7:0] ADDR_RES_HI = 8'h18;
  localparam logic [7:0] ADDR_RES_PTS = 8'h1C;
  localparam logic [7:0] ADDR_SAMP_DUR = 8'h20;
  localparam logic [7:0] ADDR_TRIG_WID = 8'h24;
  localparam logic [7:0] ADDR_WAIT_TMO = 8'h28;
  localparam logic [7:0] ADDR_SAMP_SEL = 8'h2C;
  localparam logic [7:0] ADDR_SAMP_DATA = 8'h30;
  localparam logic [7:0] ADDR_ERR_POP = 8'h34;
  localparam logic [7:0] ADDR_LIST_STAT = 8'h38;
  // ---------------------------------------------------------------
  // command opcodes (CMD[3:0])
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_CLEAR = 4'h1;
  localparam logic [3:0] OP_CURR_ENTRY = 4'h2;
  localparam logic [3:0] OP_VOLT_ENTRY = 4'h3;
  localparam logic [3:0] OP_DWELL_ENTRY = 4'h4;
  localparam logic [3:0] OP_CURR_SAMPLE = 4'h5;
  localparam logic [3:0] OP_VOLT_SAMPLE = 4'h6;
  localparam logic [3:0] OP_SAMPLE_DUR = 4'h7;
  localparam logic [3:0] OP_TRIG_WIDTH = 4'h8;
  localparam logic [3:0] OP_WAIT_TMO = 4'h9;
  localparam logic [3:0] OP_SET_RES = 4'hA;
  // ---------------------------------------------------------------
  // status bits, list types, error magnitudes, letters
  // ---------------------------------------------------------------
  localparam int ST_ERR = 0;
  localparam int ST_REJECT = 1;
  localparam int ST_TRIG_DONE = 2;
  localparam int ST_WAIT_TMO = 3;
  localparam int ST_W = 4;
  localparam logic [1:0] LT_NONE = 2'h0;
  localparam logic [1:0] LT_CURR = 2'h1;
  localparam logic [1:0] LT_VOLT = 2'h2;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_COMMAND = 8'h64;
  localparam logic [7:0] ERR_CONFLICT = 8'hDD;
  localparam logic [7:0] ERR_TOO_MUCH = 8'hDF;
  localparam logic [7:0] ERR_LENGTH = 8'hE2;
  localparam logic [7:0] CHR_VOLT = 8'h56;
  localparam logic [7:0] CHR_CURR = 8'h43;
  // ---------------------------------------------------------------
  // list limits, times in microseconds, clock timing
  // ---------------------------------------------------------------
  localparam logic [12:0] PTS_RES_MIN = 13'h0F5D;
  localparam logic [12:0] PTS_RES_MAX = 13'h170C;
  localparam logic [13:0] PTS_SAMPLE_LIM = 14'h0F5D;
  localparam logic [3:0] SAMPLE_MAX = 4'h8;
  localparam logic [8:0] AVG_MIN = 9'h002;
  localparam logic [8:0] AVG_MAX = 9'h100;
  localparam logic [31:0] DWELL_MIN_US = 32'h0000_005D;
  localparam logic [31:0] DWELL_MAX_US = 32'h0000_84D0;
  localparam logic [31:0] PULSE_MIN_US = 32'h0000_00FA;
  localparam logic [31:0] PULSE_MAX_US = 32'h0000_84D0;
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_US = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int TMR_W = 24;
  localparam int ERRQ_DEPTH = 8;
  localparam logic RST_RES_MAX = 1'b0;
  localparam logic [15:0] RST_TIME = 16'h0000;
  localparam logic [ST_W-1:0] RST_MASK = 4'h0;
endpackage

// ===== verilog/lstc_timer.sv
`timescale 1ns/1ps
// one-shot down counter; a load of zero runs until stopped
module lstc_timer #(
  parameter int W = 24
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [W-1:0] i_load,
  output logic o_busy,
  output logic o_done
);
  typedef enum logic [1:0] {LSTC_T_IDLE = 2'b00, LSTC_T_RUN = 2'b01}
    lstc_tmr_state_t;
  lstc_tmr_state_t state_r;
  logic [W-1:0] cnt_r;
  logic done_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= LSTC_T_IDLE;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        LSTC_T_IDLE: if (i_start) begin
          cnt_r <= i_load;
          state_r <= LSTC_T_RUN;
        end
        LSTC_T_RUN: if (i_stop) begin
          state_r <= LSTC_T_IDLE;
        end else if (cnt_r == W'(1)) begin
          state_r <= LSTC_T_IDLE;
          done_r <= 1'b1;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - W'(1);
        end
        default: state_r <= LSTC_T_IDLE;
      endcase
    end
  end

  assign o_busy = (state_r == LSTC_T_RUN);
  assign o_done = done_r;
endmodule

// ===== verilog/lstc_errq.sv
`timescale 1ns/1ps
// error queue; when full the newest code is dropped
module lstc_errq #(
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_push,
  input wire logic [7:0] i_code,
  input wire logic i_pop,
  output logic [7:0] o_head,
  output logic o_empty
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic do_push;
  logic do_pop;

  assign do_pop = i_pop && (cnt_r != '0);
  assign do_push = i_push && (cnt_r != (AW+1)'(DEPTH));
  assign o_empty = (cnt_r == '0);
  assign o_head = mem_r[rp_r];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (do_pop) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem_r[wp_r] <= i_code;
    end
  end
endmodule

// ===== verilog/lstc_top.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
//Operation
// - resolution query gives both dwell bounds then active point count.
// - dwell times under 93 us or over 34 ms are rejected.
// - sample average rounds down to a power of two, 2 to 256.
// - each sample appends average-count points; samples fall in that window.
// - sample of current or voltage measures that; value is the setpoint.
// - sample before any sample duration is set gives settings conflict.
// - sample needs prior current, voltage or duration command, else conflict.
// - sample with dwell and setpoint lengths unequal gives length error.
// - at most eight samples per list; ninth gives too-much-data.
// - samples count as points; over 3933 total gives too-much-data.
// - sample query gives point indices after which samples occur, V or C.
// - sample duration 0.25 to 34 ms, set once; repeat gives command error.
// - sample duration query gives value, or command error when unset.
// - trigger width set makes flag follow trigger pulse until list clear.
// - polarity on: flag conducts during pulse; off: blocks during pulse.
// - trigger width query gives value, or command error when unset.
// - wait timeout 0.25 to 34 ms; zero default waits forever.
// - wait timeout query gives value, or zero when never set.
module lstc_top #(
  parameter int unsigned P_CYC_PER_US = lstc_pkg::CYC_PER_US
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_TRIG_STEP,
  input wire logic I_WAIT_START,
  input wire logic I_WAIT_DONE,
  input wire logic I_OUTPUT_OFF,
  output logic [31:0] O_RDATA,
  output logic O_IRQ,
  output logic O_FLAG_ON,
  output logic O_WAIT_ACTIVE,
  output logic O_WAIT_TIMEOUT,
  output logic O_APPEND_VALID,
  output logic [12:0] O_APPEND_COUNT,
  output logic [31:0] O_APPEND_VALUE,
  output logic [1:0] O_APPEND_MEAS
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0] arg0_r;
  logic [31:0] arg1_r;
  logic [lstc_pkg::ST_W-1:0] status_r;
  logic [lstc_pkg::ST_W-1:0] mask_r;
  logic [12:0] pts_r;
  logic [12:0] dwell_r;
  logic [1:0] list_type_r;
  logic prev_ok_r;
  logic [3:0] samp_cnt_r;
  logic [12:0] samp_pt_r [lstc_pkg::SAMPLE_MAX];
  logic samp_meas_r [lstc_pkg::SAMPLE_MAX];
  logic [2:0] samp_sel_r;
  logic samp_set_r;
  logic [15:0] samp_dur_r;
  logic trig_mode_r;
  logic trig_pol_r;
  logic [15:0] trig_wid_r;
  logic [15:0] wait_r;
  logic res_max_r;
  logic [31:0] rdata_r;
  logic flag_r;
  logic off_s1_r;
  logic off_s2_r;
  logic app_vld_r;
  logic [12:0] app_cnt_r;
  logic [31:0] app_val_r;
  logic [1:0] app_meas_r;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  wire cmd_wr = I_WR && (I_ADDR == lstc_pkg::ADDR_CMD);
  wire [3:0] opc = I_WDATA[3:0];
  wire rd_sdur = I_RD && (I_ADDR == lstc_pkg::ADDR_SAMP_DUR);
  wire rd_trig = I_RD && (I_ADDR == lstc_pkg::ADDR_TRIG_WID);
  wire rd_err = I_RD && (I_ADDR == lstc_pkg::ADDR_ERR_POP);
  wire [12:0] res_pts = res_max_r ? lstc_pkg::PTS_RES_MAX
                                  : lstc_pkg::PTS_RES_MIN;
  wire is_entry = (opc == lstc_pkg::OP_CURR_ENTRY) ||
                  (opc == lstc_pkg::OP_VOLT_ENTRY);
  wire is_sample = (opc == lstc_pkg::OP_CURR_SAMPLE) ||
                   (opc == lstc_pkg::OP_VOLT_SAMPLE);
  wire [1:0] op_type = ((opc == lstc_pkg::OP_CURR_ENTRY) ||
                        (opc == lstc_pkg::OP_CURR_SAMPLE))
                       ? lstc_pkg::LT_CURR : lstc_pkg::LT_VOLT;
  wire cnt_big = |arg0_r[31:13];
  wire [13:0] ent_sum = {1'b0, pts_r} + {1'b0, arg0_r[12:0]};
  wire [13:0] dwl_sum = {1'b0, dwell_r} + {1'b0, arg0_r[12:0]};
  wire dwell_bad = (arg1_r < lstc_pkg::DWELL_MIN_US) ||
                   (arg1_r > lstc_pkg::DWELL_MAX_US);
  wire pulse_bad = (arg0_r < lstc_pkg::PULSE_MIN_US) ||
                   (arg0_r > lstc_pkg::PULSE_MAX_US);
  logic [8:0] avg_eff;
  logic [7:0] err_code;
  logic reject;

  // power-of-two round down, clamped to 2..256
  always_comb begin
    avg_eff = lstc_pkg::AVG_MIN;
    if (|arg0_r[31:8]) begin
      avg_eff = lstc_pkg::AVG_MAX;
    end else begin
      for (int k = 2; k < 8; k++) begin
        if (arg0_r[k]) begin
          avg_eff = 9'(1 << k);
        end
      end
    end
  end

  wire [13:0] smp_sum = {1'b0, pts_r} + {5'h00, avg_eff};

  // ---------------------------------------------------------------
  // command checking
  // ---------------------------------------------------------------
  always_comb begin
    err_code = lstc_pkg::ERR_NONE;
    reject = 1'b0;
    if (opc == lstc_pkg::OP_CLEAR || opc == lstc_pkg::OP_SET_RES) begin
      err_code = lstc_pkg::ERR_NONE;
    end else if (is_entry) begin
      if (list_type_r != lstc_pkg::LT_NONE && list_type_r != op_type) begin
        err_code = lstc_pkg::ERR_CONFLICT;
      end else if (cnt_big || ent_sum > {1'b0, res_pts}) begin
        err_code = lstc_pkg::ERR_TOO_MUCH;
      end
    end else if (opc == lstc_pkg::OP_DWELL_ENTRY) begin
      if (dwell_bad) begin
        reject = 1'b1;
      end else if (cnt_big || dwl_sum > {1'b0, res_pts}) begin
        err_code = lstc_pkg::ERR_TOO_MUCH;
      end
    end else if (is_sample) begin
      if (!samp_set_r) begin
        err_code = lstc_pkg::ERR_CONFLICT;
      end else if (!prev_ok_r) begin
        err_code = lstc_pkg::ERR_CONFLICT;
      end else if (dwell_r != pts_r) begin
        err_code = lstc_pkg::ERR_LENGTH;
      end else if (samp_cnt_r == lstc_pkg::SAMPLE_MAX) begin
        err_code = lstc_pkg::ERR_TOO_MUCH;
      end else if (smp_sum > lstc_pkg::PTS_SAMPLE_LIM) begin
        err_code = lstc_pkg::ERR_TOO_MUCH;
      end
    end else if (opc == lstc_pkg::OP_SAMPLE_DUR) begin
      if (samp_set_r) begin
        err_code = lstc_pkg::ERR_COMMAND;
      end else begin
        reject = pulse_bad;
      end
    end else if (opc == lstc_pkg::OP_TRIG_WIDTH ||
                 opc == lstc_pkg::OP_WAIT_TMO) begin
      reject = pulse_bad;
    end else begin
      err_code = lstc_pkg::ERR_COMMAND;
    end
  end

  // nothing is committed unless the command passed every check
  wire cmd_ok = cmd_wr && (err_code == lstc_pkg::ERR_NONE) && !reject;
  wire cmd_err = cmd_wr && (err_code != lstc_pkg::ERR_NONE);
  wire rd_err_cmd = (rd_sdur && !samp_set_r) ||
                    (rd_trig && !trig_mode_r);
  wire err_push = cmd_err || rd_err_cmd;
  wire [7:0] push_code = cmd_err ? err_code : lstc_pkg::ERR_COMMAND;

  // ---------------------------------------------------------------
  // error queue and timers
  // ---------------------------------------------------------------
  logic [7:0] err_head;
  logic err_empty;
  logic trig_busy;
  logic trig_done;
  logic wait_done;

  lstc_errq #(
    .DEPTH(lstc_pkg::ERRQ_DEPTH)
  ) u_errq (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RESET),
    .i_push(err_push),
    .i_code(push_code),
    .i_pop(rd_err),
    .o_head(err_head),
    .o_empty(err_empty)
  );

  wire [lstc_pkg::TMR_W-1:0] trig_load =
    lstc_pkg::TMR_W'(trig_wid_r * P_CYC_PER_US);
  wire [lstc_pkg::TMR_W-1:0] wait_load =
    lstc_pkg::TMR_W'(wait_r * P_CYC_PER_US);

  lstc_timer #(
    .W(lstc_pkg::TMR_W)
  ) u_trig_tmr (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RESET),
    .i_start(I_TRIG_STEP && trig_mode_r),
    .i_stop(cmd_ok && opc == lstc_pkg::OP_CLEAR),
    .i_load(trig_load),
    .o_busy(trig_busy),
    .o_done(trig_done)
  );

  // a zero load never expires, so an unset timeout waits forever
  lstc_timer #(
    .W(lstc_pkg::TMR_W)
  ) u_wait_tmr (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RESET),
    .i_start(I_WAIT_START),
    .i_stop(I_WAIT_DONE),
    .i_load(wait_load),
    .o_busy(O_WAIT_ACTIVE),
    .o_done(wait_done)
  );
  assign O_WAIT_TIMEOUT = wait_done;

  // ---------------------------------------------------------------
  // list and settings
  // ---------------------------------------------------------------
  wire [2:0] samp_idx = samp_cnt_r[2:0];

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      pts_r <= '0;
      dwell_r <= '0;
      list_type_r <= lstc_pkg::LT_NONE;
      prev_ok_r <= 1'b0;
      samp_cnt_r <= '0;
      samp_set_r <= 1'b0;
      samp_dur_r <= lstc_pkg::RST_TIME;
      trig_mode_r <= 1'b0;
      trig_pol_r <= 1'b0;
      trig_wid_r <= lstc_pkg::RST_TIME;
      wait_r <= lstc_pkg::RST_TIME;
      res_max_r <= lstc_pkg::RST_RES_MAX;
    end else if (cmd_ok) begin
      case (opc)
        lstc_pkg::OP_CLEAR: begin
          pts_r <= '0;
          dwell_r <= '0;
          list_type_r <= lstc_pkg::LT_NONE;
          prev_ok_r <= 1'b0;
          samp_cnt_r <= '0;
          trig_mode_r <= 1'b0;
        end
        lstc_pkg::OP_CURR_ENTRY, lstc_pkg::OP_VOLT_ENTRY: begin
          pts_r <= ent_sum[12:0];
          list_type_r <= op_type;
          prev_ok_r <= 1'b1;
        end
        lstc_pkg::OP_DWELL_ENTRY: dwell_r <= dwl_sum[12:0];
        lstc_pkg::OP_CURR_SAMPLE, lstc_pkg::OP_VOLT_SAMPLE: begin
          pts_r <= smp_sum[12:0];
          dwell_r <= smp_sum[12:0];
          samp_cnt_r <= samp_cnt_r + 4'h1;
          if (list_type_r == lstc_pkg::LT_NONE) begin
            list_type_r <= op_type;
          end
        end
        lstc_pkg::OP_SAMPLE_DUR: begin
          samp_set_r <= 1'b1;
          samp_dur_r <= arg0_r[15:0];
          prev_ok_r <= 1'b1;
        end
        lstc_pkg::OP_TRIG_WIDTH: begin
          trig_mode_r <= 1'b1;
          trig_wid_r <= arg0_r[15:0];
          trig_pol_r <= arg1_r[0];
        end
        lstc_pkg::OP_WAIT_TMO: wait_r <= arg0_r[15:0];
        lstc_pkg::OP_SET_RES: res_max_r <= arg0_r[0];
        default: res_max_r <= res_max_r;
      endcase
    end
  end

  // sample points: index of the first point in the sample window
  always_ff @(posedge I_SYS_CLK) begin
    if (cmd_ok && is_sample) begin
      samp_pt_r[samp_idx] <= pts_r;
      samp_meas_r[samp_idx] <= (opc == lstc_pkg::OP_CURR_SAMPLE);
    end
  end

  // append strobe toward the waveform table
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      app_vld_r <= 1'b0;
      app_cnt_r <= '0;
      app_val_r <= '0;
      app_meas_r <= '0;
    end else begin
      app_vld_r <= cmd_ok && (is_entry || is_sample);
      if (cmd_ok && (is_entry || is_sample)) begin
        app_cnt_r <= is_sample ? {4'h0, avg_eff} : arg0_r[12:0];
        app_val_r <= arg1_r;
        app_meas_r <= is_sample ? op_type : lstc_pkg::LT_NONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // flag transistor
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      off_s1_r <= 1'b0;
      off_s2_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      off_s1_r <= I_OUTPUT_OFF;
      off_s2_r <= off_s1_r;
      if (trig_mode_r) begin
        flag_r <= trig_pol_r ? trig_busy : !trig_busy;
      end else begin
        flag_r <= off_s2_r;
      end
    end
  end
  assign O_FLAG_ON = flag_r;

  // ---------------------------------------------------------------
  // registers, status and interrupt
  // ---------------------------------------------------------------
  wire [lstc_pkg::ST_W-1:0] ev;
  assign ev[lstc_pkg::ST_ERR] = err_push;
  assign ev[lstc_pkg::ST_REJECT] = cmd_wr && reject;
  assign ev[lstc_pkg::ST_TRIG_DONE] = trig_done;
  assign ev[lstc_pkg::ST_WAIT_TMO] = wait_done;
  wire st_wr = I_WR && (I_ADDR == lstc_pkg::ADDR_STATUS);
  wire [lstc_pkg::ST_W-1:0] st_clr =
    st_wr ? I_WDATA[lstc_pkg::ST_W-1:0] : '0;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      arg0_r <= '0;
      arg1_r <= '0;
      status_r <= '0;
      mask_r <= lstc_pkg::RST_MASK;
      samp_sel_r <= '0;
    end else begin
      // a new event beats a clear in the same cycle
      status_r <= (status_r & ~st_clr) | ev;
      if (I_WR && I_ADDR == lstc_pkg::ADDR_ARG0) begin
        arg0_r <= I_WDATA;
      end
      if (I_WR && I_ADDR == lstc_pkg::ADDR_ARG1) begin
        arg1_r <= I_WDATA;
      end
      if (I_WR && I_ADDR == lstc_pkg::ADDR_MASK) begin
        mask_r <= I_WDATA[lstc_pkg::ST_W-1:0];
      end
      if (I_WR && I_ADDR == lstc_pkg::ADDR_SAMP_SEL) begin
        samp_sel_r <= I_WDATA[2:0];
      end
    end
  end
  assign O_IRQ = |(status_r & mask_r);

  wire [7:0] letter = (list_type_r == lstc_pkg::LT_CURR)
                      ? lstc_pkg::CHR_CURR : lstc_pkg::CHR_VOLT;
  wire [31:0] samp_word = {3'h0, samp_meas_r[samp_sel_r], samp_cnt_r,
                           letter, 3'h0, samp_pt_r[samp_sel_r]};
  wire [31:0] err_word = err_empty ? 32'h0000_0000
                                   : -{24'h00_0000, err_head};
  wire [31:0] list_word = {res_max_r, trig_mode_r, samp_cnt_r,
                           dwell_r, pts_r};
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = '0;
    if (!I_RD) begin
      rd_nxt = '0;
    end else if (I_ADDR == lstc_pkg::ADDR_ARG0) begin
      rd_nxt = arg0_r;
    end else if (I_ADDR == lstc_pkg::ADDR_ARG1) begin
      rd_nxt = arg1_r;
    end else if (I_ADDR == lstc_pkg::ADDR_STATUS) begin
      rd_nxt = 32'(status_r);
    end else if (I_ADDR == lstc_pkg::ADDR_MASK) begin
      rd_nxt = 32'(mask_r);
    end else if (I_ADDR == lstc_pkg::ADDR_RES_LO) begin
      rd_nxt = res_max_r ? lstc_pkg::DWELL_MAX_US
                         : lstc_pkg::DWELL_MIN_US;
    end else if (I_ADDR == lstc_pkg::ADDR_RES_HI) begin
      rd_nxt = res_max_r ? lstc_pkg::DWELL_MIN_US
                         : lstc_pkg::DWELL_MAX_US;
    end else if (I_ADDR == lstc_pkg::ADDR_RES_PTS) begin
      rd_nxt = 32'(res_pts);
    end else if (I_ADDR == lstc_pkg::ADDR_SAMP_DUR) begin
      rd_nxt = samp_set_r ? 32'(samp_dur_r) : '0;
    end else if (I_ADDR == lstc_pkg::ADDR_TRIG_WID) begin
      rd_nxt = trig_mode_r ? {trig_pol_r, 15'h0000, trig_wid_r}
                           : '0;
    end else if (I_ADDR == lstc_pkg::ADDR_WAIT_TMO) begin
      rd_nxt = 32'(wait_r);
    end else if (I_ADDR == lstc_pkg::ADDR_SAMP_SEL) begin
      rd_nxt = 32'(samp_sel_r);
    end else if (I_ADDR == lstc_pkg::ADDR_SAMP_DATA) begin
      rd_nxt = samp_word;
    end else if (I_ADDR == lstc_pkg::ADDR_ERR_POP) begin
      rd_nxt = err_word;
    end else if (I_ADDR == lstc_pkg::ADDR_LIST_STAT) begin
      rd_nxt = list_word;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd_nxt;
    end
  end
  assign O_RDATA = rdata_r;
  assign O_APPEND_VALID = app_vld_r;
  assign O_APPEND_COUNT = app_cnt_r;
  assign O_APPEND_VALUE = app_val_r;
  assign O_APPEND_MEAS = app_meas_r;
endmodule

// ===== sim/lstc_monitor.sv
`timescale 1ns/1ps
// ----
// port checks
// ----
module lstc_monitor (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_WAIT_START,
  input wire logic I_WAIT_DONE,
  input wire logic [31:0] O_RDATA,
  input wire logic O_WAIT_ACTIVE,
  input wire logic O_WAIT_TIMEOUT,
  input wire logic O_APPEND_VALID,
  input wire logic [12:0] O_APPEND_COUNT,
  input wire logic [1:0] O_APPEND_MEAS
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  sequence samp_s;
    I_WR && I_ADDR == 8'h00 && I_WDATA[3:0] inside {4'h5, 4'h6};
  endsequence
  res_points_a: assert property (I_RD && I_ADDR == 8'h1C |=>
    O_RDATA inside {32'h0000_0F5D, 32'h0000_170C}) else $error("bad count");
  dwell_bound_a: assert property (I_RD && I_ADDR == 8'h14 |=>
    O_RDATA inside {32'h0000_005D, 32'h0000_84D0}) else $error("bad bound");
  avg_power_a: assert property (samp_s ##1 O_APPEND_VALID |->
    $onehot(O_APPEND_COUNT) && O_APPEND_COUNT inside {[2:256]})
    else $error("average not a power of two");
  append_cause_a: assert property (O_APPEND_VALID |->
    $past(I_WR) && $past(I_ADDR) == 8'h00) else $error("stray append");
  meas_kind_a: assert property (samp_s ##1 O_APPEND_VALID |->
    O_APPEND_MEAS == $past(I_WDATA[1:0])) else $error("wrong measure");
  wait_start_a: assert property (I_WAIT_START && !O_WAIT_ACTIVE
    && !I_WAIT_DONE |=> O_WAIT_ACTIVE) else $error("wait not started");
  wait_stop_a: assert property (I_WAIT_DONE && O_WAIT_ACTIVE
    && !I_WAIT_START |-> ##[1:2] !O_WAIT_ACTIVE) else $error("wait stuck");
  tmo_pulse_a: assert property (O_WAIT_TIMEOUT |->
    $past(O_WAIT_ACTIVE) ##1 !O_WAIT_TIMEOUT) else $error("bad timeout");
endmodule
bind lstc_top lstc_monitor i_mon (.I_SYS_CLK, .I_RESET, .I_ADDR, .I_WDATA,
  .I_WR, .I_RD, .I_WAIT_START, .I_WAIT_DONE, .O_RDATA, .O_WAIT_ACTIVE,
  .O_WAIT_TIMEOUT, .O_APPEND_VALID, .O_APPEND_COUNT, .O_APPEND_MEAS);

// ===== sim/lstc_step_model.sv
`timescale 1ns/1ps
// ----
// host-side list stepper
// ----
// registered so every step reaches the block one clock late
module lstc_step_model (
  input wire logic i_clk,
  input wire logic [2:0] i_req,
  output logic [2:0] o_pulse
);
  always_ff @(posedge i_clk) begin
    o_pulse <= i_req;
  end
endmodule

// ===== sim/lstc_top_tb.sv
`timescale 1ns/1ps
module lstc_top_tb;
  // ----
  // bench signals
  // ----
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, off = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [2:0] req = 3'h0, stp;
  logic [31:0] wdata = 32'h0000_0000, rdata, apval, cap;
  logic irq, flag, wact, apv;
  logic [12:0] apn;
  logic [1:0] apm;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF, V = 32'h0000_0123;
  always #20 clk = ~clk;
  lstc_step_model i_host (.i_clk(clk), .i_req(req), .o_pulse(stp));
  lstc_top #(.P_CYC_PER_US(1)) i_dut (.I_SYS_CLK(clk), .I_RESET(rst),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
    .I_TRIG_STEP(stp[0]), .I_WAIT_START(stp[1]), .I_WAIT_DONE(stp[2]),
    .I_OUTPUT_OFF(off), .O_RDATA(rdata), .O_IRQ(irq), .O_FLAG_ON(flag),
    .O_WAIT_ACTIVE(wact), .O_WAIT_TIMEOUT(), .O_APPEND_VALID(apv),
    .O_APPEND_COUNT(apn), .O_APPEND_VALUE(apval), .O_APPEND_MEAS(apm));
  // append fields packed as {0, kind, count, value low half}
  always @(posedge clk) if (apv) cap <= {1'b0, apm, apn, apval[15:0]};
  // ----
  // access tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask
  task automatic cm(input logic [3:0] op, input logic [31:0] a0, a1);
    wr(8'h04, a0);
    wr(8'h08, a1);
    wr(8'h00, {28'h000_0000, op});
  endtask
  task automatic pop(input logic [7:0] c);
    rc(8'h34, ALL, -{24'h00_0000, c});
  endtask
  task automatic ap(input logic [31:0] e);
    repeat (2) @(negedge clk);
    chk(cap, e);
  endtask
  task automatic step(input logic [2:0] k, input int n);
    @(posedge clk);
    req <= k;
    @(posedge clk);
    req <= 3'h0;
    repeat (n) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----
  // hang guard, run needs about 1500 cycles
  // ----
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("BAD %0t run did not finish", $time);
      end_of_test();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rc(8'h1C, ALL, 32'h0000_0F5D);
    rc(8'h14, ALL, 32'h0000_005D);
    rc(8'h18, ALL, 32'h0000_84D0);
    rc(8'h3C, ALL, 32'h0000_0000);
    rc(8'h20, ALL, 32'h0000_0000);
    pop(8'h64);
    rc(8'h24, ALL, 32'h0000_0000);
    pop(8'h64);
    rc(8'h28, ALL, 32'h0000_0000);
    pop(8'h00);
    step(3'h2, 300);
    chk(32'(wact), 32'h0000_0001);
    step(3'h4, 3);
    chk(32'(wact), 32'h0000_0000);
    cm(4'h5, 32'h0000_0004, V);
    pop(8'hDD);
    cm(4'h7, 32'h0000_00FA, V);
    rc(8'h20, ALL, 32'h0000_00FA);
    cm(4'h7, 32'h0000_012C, V);
    pop(8'h64);
    rc(8'h20, ALL, 32'h0000_00FA);
    cm(4'h2, 32'h0000_0003, V);
    cm(4'h4, 32'h0000_0002, 32'h0000_0064);
    cm(4'h5, 32'h0000_0004, V);
    pop(8'hE2);
    cm(4'h4, 32'h0000_0001, 32'h0000_005C);
    rc(8'h38, 32'h03FF_FFFF, 32'h0000_4003);
    cm(4'h4, 32'h0000_0001, 32'h0000_0064);
    cm(4'h5, 32'h0000_0005, V);
    ap(32'h2004_0123);
    cm(4'h6, 32'h0000_012C, V);
    ap(32'h4100_0123);
    wr(8'h2C, 32'h0000_0000);
    rc(8'h30, 32'h10FF_1FFF, 32'h1043_0003);
    wr(8'h2C, 32'h0000_0001);
    rc(8'h30, 32'h10FF_1FFF, 32'h0043_0007);
    repeat (6) cm(4'h6, 32'h0000_0002, V);
    cm(4'h6, 32'h0000_0002, V);
    pop(8'hDF);
    rc(8'h38, 32'h3C00_0000, 32'h2000_0000);
    cm(4'h1, 32'h0000_0000, V);
    cm(4'h5, 32'h0000_0002, V);
    pop(8'hDD);
    cm(4'h3, 32'h0000_0F5A, V);
    cm(4'h4, 32'h0000_0F5A, 32'h0000_0064);
    cm(4'h6, 32'h0000_0003, V);
    ap(32'h4002_0123);
    cm(4'h5, 32'h0000_0002, V);
    pop(8'hDF);
    wr(8'h2C, 32'h0000_0000);
    rc(8'h30, 32'h00FF_1FFF, 32'h0056_0F5A);
    cm(4'h8, 32'h0000_00FA, 32'h0000_0001);
    step(3'h1, 5);
    chk(32'(flag), 32'h0000_0001);
    repeat (260) @(negedge clk);
    chk(32'(flag), 32'h0000_0000);
    rc(8'h0C, 32'h0000_0004, 32'h0000_0004);
    wr(8'h10, 32'h0000_0004);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0001);
    wr(8'h0C, 32'h0000_0004);
    @(negedge clk);
    chk(32'(irq), 32'h0000_0000);
    cm(4'h8, 32'h0000_012C, 32'h0000_0000);
    step(3'h1, 5);
    chk(32'(flag), 32'h0000_0000);
    repeat (310) @(negedge clk);
    cm(4'h1, 32'h0000_0000, V);
    rc(8'h38, 32'h4000_0000, 32'h0000_0000);
    chk(32'(flag), 32'h0000_0001);
    @(posedge clk) off <= 1'b0;
    repeat (4) @(negedge clk);
    chk(32'(flag), 32'h0000_0000);
    cm(4'h9, 32'h0000_84D1, V);
    rc(8'h28, ALL, 32'h0000_0000);
    cm(4'h9, 32'h0000_00FA, V);
    rc(8'h28, ALL, 32'h0000_00FA);
    step(3'h2, 270);
    rc(8'h0C, 32'h0000_0008, 32'h0000_0008);
    cm(4'hA, 32'h0000_0001, V);
    rc(8'h1C, ALL, 32'h0000_170C);
    rc(8'h14, ALL, 32'h0000_84D0);
    end_of_test();
  end
endmodule
